// File: adc_fmt_regs.sv
// Output format configuration bank of a quad converter, written over
// a three-wire serial port (select, clock, data in) sampled on clk.
// Assumes the serial clock is well below clk/4 and a frame is
// 16 bits: 8-bit address then 8-bit data, MSB first, write only.
`default_nettype none
`include "adc_fmt_map.svh"

module adc_fmt_regs
  import adc_fmt_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Serial control port pins
  input wire logic sp_csb_b,
  input wire logic sp_sclk,
  input wire logic sp_sdio,
  // Channel access select, one bit per channel
  input wire logic [3:0] chan_sel,
  // Converter resolution in bits
  input wire logic [4:0] resolution,
  // Per-sample inputs from the converter
  input wire logic [3:0] overrange,
  input wire logic [3:0] underrange,
  input wire logic sample_strobe,
  // Per-channel outputs
  output logic [3:0] twos_comp,
  output logic [3:0] chan_out_en,
  output logic [7:0] sample_flags,
  output logic [3:0] sample_phase,
  // Global settings
  output logic [2:0] lane_drive_code,
  output logic [11:0] vref_mv,
  output logic [6:0] span_pct,
  // Readback of the shared registers and of channel 0's clock phase
  output logic [7:0] rd_lane_drive,
  output logic [7:0] rd_clock_phase,
  output logic [7:0] rd_input_range
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] cs_sync_ff, sck_sync_ff, sdi_sync_ff;
  logic [2:0] nxt_cs_sync, nxt_sck_sync, nxt_sdi_sync;
  logic sck_rise;
  logic cs_act;

  // Three stages; decisions use only stages two and three
  always_comb begin
    nxt_cs_sync = {cs_sync_ff[1:0], sp_csb_b};
    nxt_sck_sync = {sck_sync_ff[1:0], sp_sclk};
    nxt_sdi_sync = {sdi_sync_ff[1:0], sp_sdio};
    sck_rise = sck_sync_ff[1] && !sck_sync_ff[2];
    cs_act = !cs_sync_ff[1] && !cs_sync_ff[2];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_sync_ff <= 3'h7;
      sck_sync_ff <= 3'h0;
      sdi_sync_ff <= 3'h0;
    end else if (clk_en) begin
      cs_sync_ff <= nxt_cs_sync;
      sck_sync_ff <= nxt_sck_sync;
      sdi_sync_ff <= nxt_sdi_sync;
    end
  end

  // ----------------------------------------
  // Serial frame shifter
  // ----------------------------------------
  spi_state_e sp_state_ff, nxt_sp_state;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] addr_ff, nxt_addr;
  logic [2:0] bit_cnt_ff, nxt_bit_cnt;
  logic wr_stb;

  // Data bit taken from stage two, agreeing with the clock edge seen
  always_comb begin
    nxt_sp_state = sp_state_ff;
    nxt_shift = shift_ff;
    nxt_addr = addr_ff;
    nxt_bit_cnt = bit_cnt_ff;
    wr_stb = 1'b0;
    case (sp_state_ff)
      SP_IDLE: begin
        nxt_bit_cnt = 3'h0;
        if (cs_act) begin
          nxt_sp_state = SP_ADDR;
        end
      end
      SP_ADDR, SP_DATA: begin
        if (!cs_act) begin
          nxt_sp_state = SP_IDLE;
        end else if (sck_rise) begin
          nxt_shift = {shift_ff[6:0], sdi_sync_ff[1]};
          nxt_bit_cnt = bit_cnt_ff + 3'h1;
          if (bit_cnt_ff == 3'h7) begin
            if (sp_state_ff == SP_ADDR) begin
              nxt_addr = {shift_ff[6:0], sdi_sync_ff[1]};
              nxt_sp_state = SP_DATA;
            end else begin
              wr_stb = 1'b1;
              nxt_sp_state = SP_ADDR;
            end
          end
        end
      end
      default: nxt_sp_state = SP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sp_state_ff <= SP_IDLE;
      shift_ff <= 8'h00;
      addr_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
    end else if (clk_en) begin
      sp_state_ff <= nxt_sp_state;
      shift_ff <= nxt_shift;
      addr_ff <= nxt_addr;
      bit_cnt_ff <= nxt_bit_cnt;
    end
  end

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  logic [7:0] wr_data;
  logic [7:0] fmt_ctl_ff [`NUM_CHAN];
  logic [7:0] nxt_fmt_ctl [`NUM_CHAN];
  logic [7:0] drive_ff, nxt_drive;
  logic [7:0] phase_ff [`NUM_CHAN];
  logic [7:0] nxt_phase [`NUM_CHAN];
  logic [7:0] range_ff, nxt_range;

  always_comb begin
    wr_data = {shift_ff[6:0], sdi_sync_ff[1]};
    nxt_drive = drive_ff;
    nxt_range = range_ff;
    for (int c = 0; c < `NUM_CHAN; c++) begin
      nxt_fmt_ctl[c] = fmt_ctl_ff[c];
      nxt_phase[c] = phase_ff[c];
      if (wr_stb && chan_sel[c]) begin
        if (addr_ff == `OFS_OUTPUT_FORMAT_CONTROL) begin
          nxt_fmt_ctl[c] = wr_data & `MSK_OUTPUT_FORMAT_CONTROL;
        end
        if (addr_ff == `OFS_SAMPLE_CLOCK_PHASE) begin
          nxt_phase[c] = wr_data & `MSK_SAMPLE_CLOCK_PHASE;
        end
      end
    end
    if (wr_stb && addr_ff == `OFS_LANE_DRIVE_LEVEL) begin
      nxt_drive = wr_data & `MSK_LANE_DRIVE_LEVEL;
    end
    if (wr_stb && addr_ff == `OFS_INPUT_RANGE_SELECT) begin
      nxt_range = wr_data & `MSK_INPUT_RANGE_SELECT;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < `NUM_CHAN; c++) begin
        fmt_ctl_ff[c] <= `RST_OUTPUT_FORMAT_CONTROL;
        phase_ff[c] <= `RST_SAMPLE_CLOCK_PHASE;
      end
      drive_ff <= `RST_LANE_DRIVE_LEVEL;
      range_ff <= `RST_INPUT_RANGE_SELECT;
    end else if (clk_en) begin
      for (int c = 0; c < `NUM_CHAN; c++) begin
        fmt_ctl_ff[c] <= nxt_fmt_ctl[c];
        phase_ff[c] <= nxt_phase[c];
      end
      drive_ff <= nxt_drive;
      range_ff <= nxt_range;
    end
  end

  // ----------------------------------------
  // Sampling phase delay per channel
  // ----------------------------------------
  logic [3:0] strobe_dly;

  for (genvar g = 0; g < `NUM_CHAN; g++) begin : g_phase
    phase_delay_line u_dly (
      .clk(clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .strobe_in(sample_strobe),
      .tap_sel(phase_ff[g][`PHS_HI:`PHS_LO]),
      .strobe_out(strobe_dly[g])
    );
  end

  // ----------------------------------------
  // Decoded outputs
  // ----------------------------------------
  logic [3:0] nxt_twos, nxt_en, nxt_sphase;
  logic [7:0] nxt_flags;
  logic [11:0] nxt_vref;
  logic [6:0] nxt_span;
  sample_flag_e fa, fb;

  // Flags only matter when control bits exist beside the sample
  always_comb begin
    nxt_flags = 8'h00;
    for (int c = 0; c < `NUM_CHAN; c++) begin
      nxt_twos[c] = (fmt_ctl_ff[c][`FMT_HI:`FMT_LO] == 2'b01);
      nxt_en[c] = !fmt_ctl_ff[c][`DIS_BIT];
      nxt_sphase[c] = strobe_dly[c];
      case (fmt_ctl_ff[c][`FLG_HI:`FLG_LO])
        3'h1: begin fa = FLAG_OVERRANGE; fb = FLAG_UNDERRANGE; end
        3'h2: begin fa = FLAG_OVR_OR_UNDR; fb = FLAG_BLANK; end
        3'h3: begin fa = FLAG_BLANK; fb = FLAG_VALID; end
        3'h4: begin fa = FLAG_BLANK; fb = FLAG_BLANK; end
        default: begin fa = FLAG_OVR_OR_UNDR; fb = FLAG_VALID; end
      endcase
      if (resolution != `RES_DEFAULT) begin
        nxt_flags[2*c+1] = flag_val(fa, overrange[c], underrange[c]);
        nxt_flags[2*c] = flag_val(fb, overrange[c], underrange[c]);
      end
    end
  end

  function automatic logic flag_val(sample_flag_e k, logic ovr, logic und);
    case (k)
      FLAG_OVR_OR_UNDR: flag_val = ovr | und;
      FLAG_OVERRANGE: flag_val = ovr;
      FLAG_UNDERRANGE: flag_val = und;
      FLAG_VALID: flag_val = 1'b1;
      default: flag_val = 1'b0;
    endcase
  endfunction

  // Reference and span lookups
  always_comb begin
    case (range_ff[`REF_HI:`REF_LO])
      2'b00: nxt_vref = 12'h3E8;
      2'b01: nxt_vref = 12'h4B0;
      2'b11: nxt_vref = 12'h578;
      default: nxt_vref = 12'h000; // Unlisted code, no level
    endcase
    case (range_ff[`SPN_HI:`SPN_LO])
      3'h0: nxt_span = 7'h32;
      3'h1: nxt_span = 7'h39;
      3'h2: nxt_span = 7'h43;
      3'h3: nxt_span = 7'h50;
      default: nxt_span = 7'h64; // Normal span
    endcase
  end

  // All outputs registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      twos_comp <= 4'hF;
      chan_out_en <= 4'hF;
      sample_flags <= 8'h00;
      sample_phase <= 4'h0;
      lane_drive_code <= 3'h3;
      vref_mv <= 12'h3E8;
      span_pct <= 7'h64;
      rd_lane_drive <= `RST_LANE_DRIVE_LEVEL;
      rd_clock_phase <= `RST_SAMPLE_CLOCK_PHASE;
      rd_input_range <= `RST_INPUT_RANGE_SELECT;
    end else if (clk_en) begin
      twos_comp <= nxt_twos;
      chan_out_en <= nxt_en;
      sample_flags <= nxt_flags;
      sample_phase <= nxt_sphase;
      lane_drive_code <= drive_ff[`DRV_HI:`DRV_LO];
      vref_mv <= nxt_vref;
      span_pct <= nxt_span;
      rd_lane_drive <= drive_ff;
      rd_clock_phase <= phase_ff[0];
      rd_input_range <= range_ff;
    end
  end
endmodule
`default_nettype wire

// File: adc_fmt_map.svh
// Register offsets, field positions, reset values and timing counts
// for the output format configuration bank. Included by the design
// modules and the bench; holds definitions only.
// Operation
// - Format bits 00 offset binary, 01 twos complement output coding.
// - Bit 4 set disables the selected channel's converter output.
// - Flag mode ignored while resolution is the default 16 bits.
// - Phase field delays sampling by that many input clock cycles.
// - Reference code 00 1.0 V, 01 1.2 V, 11 1.4 V.
// - Span code 000 50%, 001 57%, 010 67%, 011 80%.
// - Drive code 000..111 maps to eight rising swings; reset 011.
// - Per-channel bits touch only selected channels; others are global.
`ifndef ADC_FMT_MAP_SVH
`define ADC_FMT_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_OUTPUT_FORMAT_CONTROL 8'h14
`define OFS_LANE_DRIVE_LEVEL 8'h15
`define OFS_SAMPLE_CLOCK_PHASE 8'h16
`define OFS_INPUT_RANGE_SELECT 8'h18

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_OUTPUT_FORMAT_CONTROL 8'h01
`define RST_LANE_DRIVE_LEVEL 8'h03
`define RST_SAMPLE_CLOCK_PHASE 8'h00
`define RST_INPUT_RANGE_SELECT 8'h04

// ----------------------------------------
// Writable bit masks (others reserved)
// ----------------------------------------
`define MSK_OUTPUT_FORMAT_CONTROL 8'hF3
`define MSK_LANE_DRIVE_LEVEL 8'h07
`define MSK_SAMPLE_CLOCK_PHASE 8'h70
`define MSK_INPUT_RANGE_SELECT 8'hC7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FMT_LO 0
`define FMT_HI 1
`define DIS_BIT 4
`define FLG_LO 5
`define FLG_HI 7
`define DRV_LO 0
`define DRV_HI 2
`define PHS_LO 4
`define PHS_HI 6
`define SPN_LO 0
`define SPN_HI 2
`define REF_LO 6
`define REF_HI 7

// ----------------------------------------
// Sizes
// ----------------------------------------
`define NUM_CHAN 4
`define RES_DEFAULT 5'h10
`define PHASE_DEPTH 8

`endif

// File: adc_fmt_pkg.sv
// Types shared by the format configuration bank.
// Assumes adc_fmt_map.svh sits in the include path.
`default_nettype none
package adc_fmt_pkg;
  // Flag kinds that may travel beside a sample
  typedef enum logic [2:0] {
    FLAG_OVR_OR_UNDR,
    FLAG_OVERRANGE,
    FLAG_UNDERRANGE,
    FLAG_VALID,
    FLAG_BLANK
  } sample_flag_e;
  // Serial write shifter states
  typedef enum logic [1:0] {
    SP_IDLE,
    SP_ADDR,
    SP_DATA
  } spi_state_e;
  // Reference levels, in millivolts
  typedef logic [11:0] millivolt_t;
  // Span relative to normal, in percent
  typedef logic [6:0] percent_t;
endpackage
`default_nettype wire

// File: phase_delay_line.sv
// Per-channel sample-strobe delay line with selectable tap.
// Assumes the strobe and tap are on clk; no crossing inside.
`default_nettype none
`include "adc_fmt_map.svh"

module phase_delay_line (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Strobe in and tap select
  input wire logic strobe_in,
  input wire logic [2:0] tap_sel,
  // Delayed strobe
  output logic strobe_out
);
  logic [`PHASE_DEPTH-2:0] line_ff;
  logic [`PHASE_DEPTH-2:0] nxt_line;
  logic [`PHASE_DEPTH-1:0] taps;

  // ----------------------------------------
  // Shift chain
  // ----------------------------------------
  // Tap 0 is the live strobe, so zero delay is truly zero; no stage goes unread
  always_comb begin
    nxt_line = {line_ff[`PHASE_DEPTH-3:0], strobe_in};
    taps = {line_ff, strobe_in};
    strobe_out = taps[tap_sel];
  end

  // Registers only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_ff <= '0;
    end else if (clk_en) begin
      line_ff <= nxt_line;
    end
  end
endmodule
`default_nettype wire

// File: adc_fmt_regs_assertions.sv
// Port checker for the format configuration bank.
// Assumes one clock domain and an async active-low reset.
`default_nettype none
module adc_fmt_regs_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Inputs seen by the bank
  input wire logic sp_csb_b,
  input wire logic [4:0] resolution,
  input wire logic sample_strobe,
  // Outputs of the bank
  input wire logic [7:0] sample_flags,
  input wire logic [3:0] sample_phase,
  input wire logic [2:0] lane_drive_code,
  input wire logic [11:0] vref_mv,
  input wire logic [6:0] span_pct,
  input wire logic [7:0] rd_lane_drive,
  input wire logic [7:0] rd_clock_phase,
  input wire logic [7:0] rd_input_range
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Reference code to millivolts; code 10 gives zero
  function automatic logic [11:0] vref_of(input logic [1:0] c);
    return c == 2'h0 ? 12'h3E8 : c == 2'h1 ? 12'h4B0 : c == 2'h3 ? 12'h578 : 12'h000;
  endfunction
  // Span code to percent; unlisted codes mean normal span
  function automatic logic [6:0] span_of(input logic [2:0] c);
    return c == 3'h0 ? 7'h32 : c == 3'h1 ? 7'h39 : c == 3'h2 ? 7'h43 : c == 3'h3 ? 7'h50 : 7'h64;
  endfunction
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence port_idle_s;
    sp_csb_b [*8];
  endsequence
  sequence phase0_held_s;
    ($stable(rd_clock_phase) && rd_clock_phase[6:4] == 3'h0) [*8];
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_VREF_MAP: assert property (
    $stable(rd_input_range) |-> vref_mv == vref_of(rd_input_range[7:6]))
    else $error("vref does not follow reference code");
  AST_SPAN_MAP: assert property (
    $stable(rd_input_range) |-> span_pct == span_of(rd_input_range[2:0]))
    else $error("span does not follow span code");
  AST_DRIVE_RB: assert property (
    $stable(rd_lane_drive) |-> lane_drive_code == rd_lane_drive[2:0])
    else $error("drive code differs from its register");
  AST_RSV_DRIVE: assert property (rd_lane_drive[7:3] == 5'h00)
    else $error("reserved drive bits set");
  AST_RSV_PHASE: assert property (rd_clock_phase[7] == 1'b0 && rd_clock_phase[3:0] == 4'h0)
    else $error("reserved phase bits set");
  AST_RSV_RANGE: assert property (rd_input_range[5:3] == 3'h0)
    else $error("reserved range bits set");
  AST_FLAG16: assert property ((resolution == 5'h10) [*2] |-> sample_flags == 8'h00)
    else $error("flags present at default resolution");
  AST_PHASE0: assert property (phase0_held_s |-> sample_phase[0] == $past(sample_strobe))
    else $error("zero phase strobe not one cycle late");
  AST_QUIET: assert property (port_idle_s |=> $stable(lane_drive_code) && $stable(span_pct))
    else $error("global setting moved with port idle");
endmodule
bind adc_fmt_regs adc_fmt_regs_assertions chk_u (.clk, .rst_b, .sp_csb_b, .resolution,
  .sample_strobe, .sample_flags, .sample_phase, .lane_drive_code, .vref_mv, .span_pct,
  .rd_lane_drive, .rd_clock_phase, .rd_input_range);
`default_nettype wire

// File: adc_fmt_regs_tb.sv
// Self-checking bench for the format configuration bank.
// Assumes the bank, its map header and its checker compile beside it.
`default_nettype none
`include "adc_fmt_map.svh"
module adc_fmt_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, csb_b = 1'b1, sclk = 1'b0, sdio = 1'b0, strobe = 1'b0;
  logic [3:0] chan_sel = 4'h0, undr = 4'h0, ovr = 4'h0, twos_comp, chan_out_en, sample_phase;
  logic en = 1'b1;
  logic [4:0] res = 5'h10;
  logic [7:0] sample_flags, rd_lane_drive, rd_clock_phase, rd_input_range;
  logic [2:0] lane_drive_code;
  logic [11:0] vref_mv;
  logic [6:0] span_pct;
  logic [31:0] r;
  logic [11:0] exp_q[$];
  int kind_q[$];
  int n_errors = 0, compares = 0, dly = 0;
  event chk_ev;
  // Tables for range codes, flag modes and phase taps
  logic [1:0] rc[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [11:0] vt[4] = '{12'h3E8, 12'h4B0, 12'h578, 12'h000};
  logic [6:0] st[4] = '{7'h32, 7'h39, 7'h43, 7'h50};
  logic [2:0] fm[6] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h0, 3'h6};
  logic [2:0] pc[3] = '{3'h0, 3'h5, 3'h7};
  always #5 clk = ~clk;
  adc_fmt_regs dut_u (.clk(clk), .rst_b(rst_b), .clk_en(en), .sp_csb_b(csb_b),
    .sp_sclk(sclk), .sp_sdio(sdio), .chan_sel(chan_sel), .resolution(res),
    .overrange(ovr), .underrange(undr), .sample_strobe(strobe), .twos_comp(twos_comp),
    .chan_out_en(chan_out_en), .sample_flags(sample_flags), .sample_phase(sample_phase),
    .lane_drive_code(lane_drive_code), .vref_mv(vref_mv), .span_pct(span_pct),
    .rd_lane_drive(rd_lane_drive), .rd_clock_phase(rd_clock_phase),
    .rd_input_range(rd_input_range));
  // ----------------------------------------
  // Driver tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Frame of nbits, MSB first; short frames abort on select rising
  task automatic frame(input logic [15:0] word, input int nbits);
    csb_b = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      sdio = word[i];
      tick(5);
      sclk = 1'b1;
      tick(5);
      sclk = 1'b0;
    end
    sdio = ~sdio;
    tick(8);
    csb_b = 1'b1;
    tick(6);
  endtask
  task automatic note(input int k, input logic [11:0] v);
    kind_q.push_back(k);
    exp_q.push_back(v);
    -> chk_ev;
  endtask
  function automatic logic [11:0] seen(input int k);
    case (k)
      0: return {8'h00, twos_comp};
      1: return {8'h00, chan_out_en};
      2: return {4'h0, sample_flags};
      3: return {9'h000, lane_drive_code};
      4: return vref_mv;
      5: return {5'h00, span_pct};
      6: return {4'h0, rd_lane_drive};
      7: return {4'h0, rd_clock_phase};
      8: return {4'h0, rd_input_range};
      10: return {8'h00, sample_phase};
      default: return dly[11:0];
    endcase
  endfunction
  // Expected flag pairs per mode; first flag sits in the upper bit of a pair
  function automatic logic [7:0] flag_exp(input logic [2:0] m, input logic [3:0] o,
      input logic [3:0] u);
    logic [7:0] f;
    f = 8'h00;
    for (int c = 0; c < 4; c++) begin
      case (m)
        3'h1: f[2*c+:2] = {o[c], u[c]};
        3'h2: f[2*c+:2] = {o[c] | u[c], 1'b0};
        3'h3: f[2*c+:2] = 2'h1;
        3'h4: f[2*c+:2] = 2'h0;
        default: f[2*c+:2] = {o[c] | u[c], 1'b1};
      endcase
    end
    return f;
  endfunction
  task automatic check(input logic [11:0] got, input logic [11:0] want);
    compares++;
    if (got !== want) begin
      n_errors++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, got, want);
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Monitor drains notes in order; several may land in one step
  always @(chk_ev) begin
    while (exp_q.size() > 0) check(seen(kind_q.pop_front()), exp_q.pop_front());
  end
  // Watchdog well beyond the 25 or so frames of the run
  initial begin
    #200us;
    n_errors++;
    print_verdict();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'hBE7D));
    tick(20);
    rst_b = 1'b1;
    tick(2);
    note(0, 12'h00F);
    note(1, 12'h00F);
    note(3, 12'h003);
    note(4, 12'h3E8);
    note(5, 12'h064);
    note(7, 12'h000);
    note(8, 12'h004);
    $display("Reset test done");
    // Reserved bits 3:2 set as well; only selected channels change
    chan_sel = 4'h5;
    frame({`OFS_OUTPUT_FORMAT_CONTROL, 8'h1C}, 16);
    note(0, 12'h00A);
    note(1, 12'h00A);
    chan_sel = 4'h2;
    frame({`OFS_OUTPUT_FORMAT_CONTROL, 8'h00}, 16);
    note(0, 12'h008);
    note(1, 12'h00A);
    $display("Format test done");
    for (int i = 0; i < 8; i++) begin
      r = $urandom();
      frame({`OFS_LANE_DRIVE_LEVEL, r[4:0], 3'(i)}, 16);
      note(6, 12'(i));
      note(3, 12'(i));
    end
    for (int i = 0; i < 4; i++) begin
      r = $urandom();
      frame({`OFS_INPUT_RANGE_SELECT, rc[i], r[2:0], 3'(i)}, 16);
      note(4, vt[i]);
      note(5, {5'h00, st[i]});
      note(8, {4'h0, rc[i], 3'h0, 3'(i)});
    end
    $display("Drive and range tests done");
    // Unmapped write, then an aborted frame; nothing may change
    frame({8'h17, 8'hFF}, 16);
    frame({`OFS_LANE_DRIVE_LEVEL, 8'h02}, 12);
    note(6, 12'h007);
    note(8, 12'h083);
    // Frozen clock enable: a whole frame must leave no trace
    en = 1'b0;
    frame({`OFS_LANE_DRIVE_LEVEL, 8'h02}, 16);
    en = 1'b1;
    tick(8);
    note(6, 12'h007);
    note(3, 12'h007);
    $display("Refusal test done");
    res = 5'h0E;
    chan_sel = 4'hF;
    foreach (fm[i]) begin
      r = $urandom();
      ovr = r[3:0];
      undr = r[7:4];
      frame({`OFS_OUTPUT_FORMAT_CONTROL, fm[i], 5'h01}, 16);
      strobe = 1'b1;
      tick(1);
      strobe = 1'b0;
      tick(3);
      note(2, {4'h0, flag_exp(fm[i], ovr, undr)});
    end
    res = 5'h10;
    tick(3);
    note(2, 12'h000);
    $display("Flag test done");
    foreach (pc[i]) begin
      r = $urandom();
      frame({`OFS_SAMPLE_CLOCK_PHASE, r[7], pc[i], r[3:0]}, 16);
      note(7, {5'h00, pc[i], 4'h0});
      strobe = 1'b1;
      tick(1);
      strobe = 1'b0;
      dly = 1;
      while (sample_phase[0] !== 1'b1 && dly < 20) begin
        tick(1);
        dly++;
      end
      note(9, 12'(pc[i]) + 12'h001);
      note(10, 12'h00F);
    end
    $display("Phase test done");
    tick(2);
    print_verdict();
  end
endmodule
`default_nettype wire
